// File: hdl/hsp_host_serial.sv
// Host serial port control: UART, serial buffers, flow control, packetizing, command mode.
// Assumes one 10 MHz clock, a Wishbone master, a radio side that streams packets in and out.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - With inbound pause on, raise clear-to-send when receive buffer free space reaches 17.
// - Lower clear-to-send again only when receive buffer free space is at least 34.
// - With host hold on, send no transmit-buffer byte while request-to-send is high.
// - A radio packet that does not fit the transmit buffer is dropped whole.
// - Host hold and inbound pause flow enables are two independent settings.
// - Packetize after the idle gap timeout; timeout zero packetizes on any character.
// - Packetize as soon as the receive buffer holds 72 bytes.
// - On entry sequence, first send buffered characters, then enter command mode.
// - Entry is guard silence, three escape characters within guard, guard silence.
// - After valid entry, send O, K, carriage return, after pending output.
// - Command idle timeout returns to idle mode if no valid command arrives.
// - Leave command mode command with carriage return returns to idle mode.
// - Parameter command without value reads back the stored value.
// - Each executed command answers OK, a read answers the value, or ERROR on failure.
// - New settings stay pending until apply command or leaving command mode.
// - Reset restores last saved settings; only the save command persists values.
// - Baud rate setting defaults to code 3, 9600 bps.
// - Idle goes to transmit on ready data, to command on entry sequence.
// - Received radio packet payload is copied into the transmit buffer.
// - Bytes framed as low start, eight data bits LSB first, high stop.
module hsp_host_serial #(
  parameter int MS_CYCLES = hsp_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic nvm_init_i,
  input wire hsp_pkg::hsp_wbm_t wb_i,
  output var hsp_pkg::hsp_wbs_t wb_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic rts_n_i,
  output logic cts_n_o,
  input wire hsp_pkg::hsp_rfin_t rf_in_i,
  output var hsp_pkg::hsp_rfout_t rf_out_o,
  input wire logic rf_out_ready_i,
  output var hsp_pkg::hsp_mode_t mode_o
);
  import hsp_pkg::*;

  hsp_st_t st_ff, nxt_st, rst_st;
  logic [7:0] rb_mem [128];
  logic [7:0] tb_mem [128];
  logic rb_we, tb_we, rx_done, ms_tk, bt_tk, trig, fits, perr, known;
  logic [6:0] rb_wa, tb_wa;
  logic [7:0] rb_wd, tb_wd, rb_cnt, tb_cnt, ch;
  logic [15:0] bc, cmd, val, rd, vmax;
  logic [3:0] np;
  logic [4:0] hx;

  // Hex character to nibble, with a valid flag on top
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= CH_0 && c <= CH_9)
      return {1'b1, 4'(c - CH_0)};
    if (c >= CH_A && c <= CH_F)
      return {1'b1, 4'(c - CH_HEX_OFS)};
    return 5'h00;
  endfunction

  // Nibble to upper-case hex character
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? (CH_0 + {4'h0, n}) : (CH_HEX_OFS + {4'h0, n});
  endfunction

  // Reset image: settings come from the saved copy, or defaults on first power-up
  always_comb
  begin
    rst_st = '0;
    rst_st.mode = M_IDLE;
    // restore saved settings; defaults when nvm_init_i is high
    rst_st.saved = nvm_init_i ? CFG_DEFAULT : st_ff.saved;
    rst_st.act = rst_st.saved;
    rst_st.pend = rst_st.saved;
    rst_st.rs = 3'h7;
    rst_st.rx_lvl = 1'b1;
    rst_st.ts = 3'h7;
    rst_st.rts_lvl = 1'b1;
    rst_st.txd = 1'b1;
    rst_st.cts_n = ~rst_st.act.inbound_pause_flow_enable;
  end

  // Buffer memories, written only; reads are asynchronous
  always_ff @(posedge clk_i)
  begin
    if (rb_we)
      rb_mem[rb_wa] <= rb_wd;
    if (tb_we)
      tb_mem[tb_wa] <= tb_wd;
  end

  // Next-state logic of the whole block
  always_comb
  begin
    nxt_st = st_ff;
    rb_we = 1'b0;
    tb_we = 1'b0;
    rb_wa = st_ff.rb_wp[6:0];
    tb_wa = st_ff.tb_wp[6:0];
    rb_wd = 8'h00;
    tb_wd = rf_in_i.data;
    rx_done = 1'b0;
    fits = 1'b0;
    perr = 1'b0;
    known = 1'b0;
    hx = 5'h00;
    val = 16'h0000;
    rd = 16'h0000;
    vmax = 16'h0000;
    cmd = 16'h0000;
    np = 4'h0;
    ch = st_ff.rx_sh;
    rb_cnt = st_ff.rb_wp - st_ff.rb_rp;
    tb_cnt = st_ff.tb_wp - st_ff.tb_rp;
    bc = BIT_CYC[st_ff.act.baud_rate_setting];

    // Pin synchronisers; a level counts once the second and third stage agree
    nxt_st.rs = {st_ff.rs[1:0], rxd_i};
    nxt_st.ts = {st_ff.ts[1:0], rts_n_i};
    if (st_ff.rs[2] == st_ff.rs[1])
      nxt_st.rx_lvl = st_ff.rs[2];
    if (st_ff.ts[2] == st_ff.ts[1])
      nxt_st.rts_lvl = st_ff.ts[2];

    // Millisecond and bit-period enables
    ms_tk = st_ff.ms_div == 16'(MS_CYCLES - 1);
    nxt_st.ms_div = ms_tk ? 16'h0000 : st_ff.ms_div + 16'h0001;
    bt_tk = st_ff.bt_cnt >= bc - 16'h0001;
    nxt_st.bt_cnt = bt_tk ? 16'h0000 : st_ff.bt_cnt + 16'h0001;
    if (ms_tk && st_ff.quiet_ms != 16'hffff)
      nxt_st.quiet_ms = st_ff.quiet_ms + 16'h0001;
    if (ms_tk && st_ff.esc_ms != 16'hffff)
      nxt_st.esc_ms = st_ff.esc_ms + 16'h0001;
    if (bt_tk && st_ff.gap_cnt != 12'hfff)
      nxt_st.gap_cnt = st_ff.gap_cnt + 12'h001;

    if (!st_ff.rx_busy)
    begin
      if (!st_ff.rx_lvl)
      begin
        nxt_st.rx_busy = 1'b1;
        nxt_st.rx_cnt = bc >> 1;
        nxt_st.rx_bit = 4'h0;
      end
    end
    else if (st_ff.rx_cnt != 16'h0000)
      nxt_st.rx_cnt = st_ff.rx_cnt - 16'h0001;
    else
    begin
      nxt_st.rx_cnt = bc - 16'h0001;
      nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
      if (st_ff.rx_bit == 4'h0 && st_ff.rx_lvl)
        nxt_st.rx_busy = 1'b0; // Glitch, not a start bit
      else if (st_ff.rx_bit == STOP_BIT)
      begin
        nxt_st.rx_busy = 1'b0;
        rx_done = st_ff.rx_lvl; // Bad stop bit drops the byte
      end
      else if (st_ff.rx_bit != 4'h0)
        nxt_st.rx_sh = {st_ff.rx_lvl, st_ff.rx_sh[7:1]};
    end

    // transmitter shifts start, data LSB first, stop
    if (st_ff.tx_busy)
    begin
      if (st_ff.tx_cnt != 16'h0000)
        nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
      else if (st_ff.tx_bit == FRAME_END)
        nxt_st.tx_busy = 1'b0;
      else
      begin
        nxt_st.tx_cnt = bc - 16'h0001;
        nxt_st.txd = st_ff.tx_sh[0];
        nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
        nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
      end
    end
    else if (!(st_ff.act.host_hold_flow_enable && st_ff.rts_lvl))
    begin
      if (tb_cnt != 8'h00)
      begin
        nxt_st.tx_busy = 1'b1;
        nxt_st.tx_cnt = 16'h0000;
        nxt_st.tx_bit = 4'h0;
        nxt_st.tx_sh = {1'b1, tb_mem[st_ff.tb_rp[6:0]], 1'b0};
        nxt_st.tb_rp = st_ff.tb_rp + 8'h01;
      end
      else if (st_ff.rp_n != 3'h0)
      begin
        nxt_st.tx_busy = 1'b1;
        nxt_st.tx_cnt = 16'h0000;
        nxt_st.tx_bit = 4'h0;
        nxt_st.tx_sh = {1'b1, st_ff.rp[47:40], 1'b0};
        nxt_st.rp = {st_ff.rp[39:0], 8'h00};
        nxt_st.rp_n = st_ff.rp_n - 3'h1;
      end
    end

    // Serial input in transparent operation, with escape sequence tracking
    if (rx_done)
    begin
      nxt_st.quiet_ms = 16'h0000;
      nxt_st.gap_cnt = 12'h000;
    end
    if (rx_done && st_ff.mode != M_CMD && rb_cnt != RB_DEPTH)
    begin
      rb_we = 1'b1;
      rb_wd = ch;
      nxt_st.rb_wp = st_ff.rb_wp + 8'h01;
      // count escape characters inside the guard window
      if (ch == st_ff.act.escape_char && ((st_ff.esc_n == 2'h0 && st_ff.quiet_ms >= st_ff.act.silence_guard_time)
          || (st_ff.esc_n != 2'h0 && st_ff.esc_n != ESC_COUNT && st_ff.esc_ms < st_ff.act.silence_guard_time)))
      begin
        nxt_st.esc_n = st_ff.esc_n + 2'h1;
        if (st_ff.esc_n == 2'h0)
          nxt_st.esc_ms = 16'h0000;
      end
      // wrong or extra character abandons the sequence
      else
        nxt_st.esc_n = 2'h0;
    end
    // window over with too few escape characters
    else if (!rx_done && st_ff.esc_n != 2'h0 && st_ff.esc_n != ESC_COUNT
             && st_ff.esc_ms >= st_ff.act.silence_guard_time)
      nxt_st.esc_n = 2'h0;
    else if (!rx_done && st_ff.esc_n == ESC_COUNT && st_ff.quiet_ms >= st_ff.act.silence_guard_time)
    begin
      nxt_st.esc_n = 2'h0;
      nxt_st.rb_wp = st_ff.rb_wp - {6'h00, ESC_COUNT};
      nxt_st.go_cmd = 1'b1;
    end

    // gap timeout; full payload; flush before command mode
    trig = st_ff.pk_left == 8'h00 && st_ff.esc_n == 2'h0 && !st_ff.pk_hold && rb_cnt != 8'h00
           && (st_ff.go_cmd || rb_cnt >= MAX_PAYLOAD || st_ff.act.idle_gap_timeout == 8'h00
               || st_ff.gap_cnt >= 12'(st_ff.act.idle_gap_timeout) * CHAR_BITS);
    if (trig)
      nxt_st.pk_left = (rb_cnt > MAX_PAYLOAD) ? MAX_PAYLOAD : rb_cnt;

    // Packet output stage toward the radio
    if (st_ff.rfo.valid && rf_out_ready_i)
      nxt_st.rfo.valid = 1'b0;
    if (st_ff.pk_left != 8'h00 && (!st_ff.rfo.valid || rf_out_ready_i))
    begin
      nxt_st.rfo = '{valid: 1'b1, last: st_ff.pk_left == 8'h01, data: rb_mem[st_ff.rb_rp[6:0]]};
      nxt_st.rb_rp = st_ff.rb_rp + 8'h01;
      nxt_st.pk_left = st_ff.pk_left - 8'h01;
    end

    // radio payload into the transmit buffer
    if (rf_in_i.valid)
    begin
      // decide on the first beat whether the whole packet fits
      fits = rf_in_i.first ? (TB_DEPTH - tb_cnt >= rf_in_i.len) : st_ff.rf_act;
      nxt_st.rf_act = fits && !rf_in_i.last;
      if (fits)
      begin
        tb_we = 1'b1;
        nxt_st.tb_wp = st_ff.tb_wp + 8'h01;
      end
    end

    unique case (st_ff.mode)
      M_IDLE, M_TX, M_RX:
      begin
        if (st_ff.go_cmd && rb_cnt == 8'h00 && st_ff.pk_left == 8'h00 && !st_ff.rfo.valid)
        begin
          nxt_st.mode = M_CMD;
          nxt_st.go_cmd = 1'b0;
          nxt_st.cto_ms = 24'h000000;
          nxt_st.ln_n = 4'h0;
          nxt_st.rp = {CH_O, CH_K, CH_CR, 24'h000000};
          nxt_st.rp_n = 3'h3;
        end
        else if (trig || st_ff.pk_left != 8'h00)
          nxt_st.mode = M_TX;
        else if (st_ff.rf_act)
          nxt_st.mode = M_RX;
        else
          nxt_st.mode = M_IDLE;
      end
      M_CMD:
      begin
        if (ms_tk)
          nxt_st.cto_ms = st_ff.cto_ms + 24'h000001;
        if (rx_done && ch != CH_CR)
        begin
          nxt_st.ln = {st_ff.ln[55:0], ch};
          if (st_ff.ln_n <= LINE_MAX)
            nxt_st.ln_n = st_ff.ln_n + 4'h1;
        end
        else if (rx_done)
        begin
          nxt_st.ln_n = 4'h0;
          np = st_ff.ln_n - LINE_HDR;
          cmd = 16'(st_ff.ln >> {st_ff.ln_n - LINE_HDR, 3'h0});
          perr = st_ff.ln_n < LINE_HDR || st_ff.ln_n > LINE_MAX
                 || 16'(st_ff.ln >> {st_ff.ln_n - 4'h2, 3'h0}) != {CH_A, CH_T};
          for (int i = 0; i < 4; i++)
          begin
            hx = hex_val(st_ff.ln[8*i +: 8]);
            if (4'(i) < np)
            begin
              val[4*i +: 4] = hx[3:0];
              perr = perr | ~hx[4];
            end
          end
          // Current value and range of each parameter
          case (cmd)
            CMD_HOLD: {known, vmax, rd} = {17'h10001, 15'h0000, st_ff.pend.host_hold_flow_enable};
            CMD_PAUSE: {known, vmax, rd} = {17'h10001, 15'h0000, st_ff.pend.inbound_pause_flow_enable};
            CMD_GAP: {known, vmax, rd} = {17'h100ff, 8'h00, st_ff.pend.idle_gap_timeout};
            CMD_GUARD: {known, vmax, rd} = {17'h1ffff, st_ff.pend.silence_guard_time};
            CMD_ESC: {known, vmax, rd} = {17'h100ff, 8'h00, st_ff.pend.escape_char};
            CMD_CTO: {known, vmax, rd} = {17'h1ffff, st_ff.pend.command_idle_timeout};
            CMD_BAUD: {known, vmax, rd} = {17'h10007, 13'h0000, st_ff.pend.baud_rate_setting};
            default: {known, vmax, rd} = 33'h000000000;
          endcase
          perr = perr || (known && val > vmax)
                 || (!known && (np != 4'h0 || (cmd != CMD_LEAVE && cmd != CMD_APPLY && cmd != CMD_SAVE)));
          // answer OK, the value for a read, or ERROR if the command fails
          nxt_st.rp = {CH_O, CH_K, CH_CR, 24'h000000};
          nxt_st.rp_n = 3'h3;
          if (perr)
          begin
            nxt_st.rp = {CH_E, CH_R, CH_R, CH_O, CH_R, CH_CR};
            nxt_st.rp_n = 3'h6;
          end
          else
          begin
            // valid command restarts the idle timeout
            nxt_st.cto_ms = 24'h000000;
            if (known && np == 4'h0)
            begin
              nxt_st.rp = {hex_chr(rd[15:12]), hex_chr(rd[11:8]), hex_chr(rd[7:4]), hex_chr(rd[3:0]), CH_CR, 8'h00};
              nxt_st.rp_n = 3'h5;
            end
            // independent flow enables; writes stay pending
            case (cmd)
              CMD_HOLD: nxt_st.pend.host_hold_flow_enable = val[0];
              CMD_PAUSE: nxt_st.pend.inbound_pause_flow_enable = val[0];
              CMD_GAP: nxt_st.pend.idle_gap_timeout = val[7:0];
              CMD_GUARD: nxt_st.pend.silence_guard_time = val;
              CMD_ESC: nxt_st.pend.escape_char = val[7:0];
              CMD_CTO: nxt_st.pend.command_idle_timeout = val;
              CMD_BAUD: nxt_st.pend.baud_rate_setting = val[2:0];
              CMD_APPLY: nxt_st.act = st_ff.pend;
              CMD_SAVE: nxt_st.saved = st_ff.pend;
              CMD_LEAVE:
              begin
                nxt_st.act = st_ff.pend;
                nxt_st.mode = M_IDLE;
              end
              default: nxt_st.act = st_ff.act;
            endcase
            // Field write with no value given is a read, so undo it
            if (known && np == 4'h0)
              nxt_st.pend = st_ff.pend;
          end
        end
        // command idle timeout; exit applies pending settings
        else if (st_ff.cto_ms >= 24'(st_ff.act.command_idle_timeout) * CTO_UNIT_MS)
        begin
          nxt_st.act = st_ff.pend;
          nxt_st.mode = M_IDLE;
        end
      end
    endcase

    // deassert near full; reassert with room again
    if (!st_ff.act.inbound_pause_flow_enable)
      nxt_st.cts_n = 1'b0;
    else if (RB_DEPTH - rb_cnt <= CTS_OFF_FREE)
      nxt_st.cts_n = 1'b1;
    else if (RB_DEPTH - rb_cnt >= CTS_ON_FREE)
      nxt_st.cts_n = 1'b0;

    // Wishbone slave: one wait state, unmapped reads return zero
    nxt_st.ack = wb_i.cyc && wb_i.stb && !st_ff.ack;
    nxt_st.dat = 32'h00000000;
    if (nxt_st.ack && !wb_i.we)
    begin
      case (wb_i.adr)
        REG_STATUS: nxt_st.dat = {8'h00, tb_cnt, rb_cnt, st_ff.esc_n, st_ff.rts_lvl, st_ff.cts_n, st_ff.mode};
        REG_CFG: nxt_st.dat = {16'h0000, st_ff.act.escape_char, 3'h0, st_ff.act.inbound_pause_flow_enable,
                               st_ff.act.host_hold_flow_enable, st_ff.act.baud_rate_setting};
        REG_CTRL: nxt_st.dat = {31'h00000000, st_ff.pk_hold};
        default: nxt_st.dat = 32'h00000000;
      endcase
    end
    if (nxt_st.ack && wb_i.we && wb_i.adr == REG_CTRL && wb_i.sel[0])
    begin
      nxt_st.pk_hold = wb_i.dat[0];
      if (wb_i.dat[1])
        nxt_st.tb_rp = nxt_st.tb_wp; // Flush transmit buffer
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    st_ff <= rst_i ? rst_st : nxt_st;
  end

  // Outputs straight from flip-flops
  assign txd_o = st_ff.txd;
  assign cts_n_o = st_ff.cts_n;
  assign rf_out_o = st_ff.rfo;
  assign mode_o = st_ff.mode;
  assign wb_o = '{ack: st_ff.ack, dat: st_ff.dat};

endmodule // hsp_host_serial

`default_nettype wire

// File: shared/hsp_pkg.sv
// Constants and types of the host serial port control block.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package hsp_pkg;
  localparam int CLK_HZ = 10_000_000;
  // Cycles per millisecond; above 4096, so the top module takes it as a parameter
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam logic [7:0] RB_DEPTH = 8'h80;
  localparam logic [7:0] TB_DEPTH = 8'h80;
  localparam logic [7:0] CTS_OFF_FREE = 8'h11;
  localparam logic [7:0] CTS_ON_FREE = 8'h22;
  localparam logic [7:0] MAX_PAYLOAD = 8'h48;
  localparam logic [11:0] CHAR_BITS = 12'h00a;
  localparam logic [23:0] CTO_UNIT_MS = 24'h000064;
  localparam logic [1:0] ESC_COUNT = 2'h3;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam logic [3:0] FRAME_END = 4'ha;
  localparam logic [3:0] LINE_HDR = 4'h4;
  localparam logic [3:0] LINE_MAX = 4'h8;
  // Bit periods in clock cycles, rounded down, for baud codes 0..7
  localparam logic [15:0] BIT_CYC [8] = '{16'(CLK_HZ / 1200), 16'(CLK_HZ / 2400), 16'(CLK_HZ / 4800),
    16'(CLK_HZ / 9600), 16'(CLK_HZ / 19200), 16'(CLK_HZ / 38400), 16'(CLK_HZ / 57600), 16'(CLK_HZ / 115200)};
  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  // Characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_HEX_OFS = 8'h37;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_K = 8'h4b;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_R = 8'h52;
  // Two-letter command codes
  localparam logic [15:0] CMD_LEAVE = 16'h434e;
  localparam logic [15:0] CMD_APPLY = 16'h4143;
  localparam logic [15:0] CMD_SAVE = 16'h5752;
  localparam logic [15:0] CMD_HOLD = 16'h4436;
  localparam logic [15:0] CMD_PAUSE = 16'h4437;
  localparam logic [15:0] CMD_GAP = 16'h524f;
  localparam logic [15:0] CMD_GUARD = 16'h4754;
  localparam logic [15:0] CMD_ESC = 16'h4343;
  localparam logic [15:0] CMD_CTO = 16'h4354;
  localparam logic [15:0] CMD_BAUD = 16'h4244;

  typedef enum logic [3:0] {M_IDLE = 4'h1, M_TX = 4'h2, M_RX = 4'h4, M_CMD = 4'h8} hsp_mode_t;

  typedef struct packed {
    logic host_hold_flow_enable;
    logic inbound_pause_flow_enable;
    logic [7:0] idle_gap_timeout;
    logic [15:0] silence_guard_time;
    logic [7:0] escape_char;
    logic [15:0] command_idle_timeout;
    logic [2:0] baud_rate_setting;
  } hsp_cfg_t;

  localparam hsp_cfg_t CFG_DEFAULT = '{host_hold_flow_enable: 1'b0, inbound_pause_flow_enable: 1'b1,
    idle_gap_timeout: 8'h03, silence_guard_time: 16'h03e8, escape_char: 8'h2b,
    command_idle_timeout: 16'h0064, baud_rate_setting: 3'h3};

  typedef struct packed {logic cyc; logic stb; logic we; logic [3:0] sel; logic [7:0] adr; logic [31:0] dat;} hsp_wbm_t;
  typedef struct packed {logic ack; logic [31:0] dat;} hsp_wbs_t;
  typedef struct packed {logic valid; logic first; logic last; logic [7:0] len; logic [7:0] data;} hsp_rfin_t;
  typedef struct packed {logic valid; logic last; logic [7:0] data;} hsp_rfout_t;

  typedef struct packed {
    hsp_mode_t mode;
    hsp_cfg_t act;
    hsp_cfg_t pend;
    hsp_cfg_t saved;
    logic [2:0] rs;
    logic rx_lvl;
    logic [2:0] ts;
    logic rts_lvl;
    logic [15:0] ms_div;
    logic [15:0] bt_cnt;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic txd;
    logic [7:0] rb_wp;
    logic [7:0] rb_rp;
    logic [7:0] pk_left;
    logic [7:0] tb_wp;
    logic [7:0] tb_rp;
    logic rf_act;
    logic cts_n;
    logic [15:0] quiet_ms;
    logic [15:0] esc_ms;
    logic [1:0] esc_n;
    logic [11:0] gap_cnt;
    logic go_cmd;
    logic [23:0] cto_ms;
    logic [63:0] ln;
    logic [3:0] ln_n;
    logic [47:0] rp;
    logic [2:0] rp_n;
    hsp_rfout_t rfo;
    logic pk_hold;
    logic ack;
    logic [31:0] dat;
  } hsp_st_t;
endpackage

// File: verif/hsp_host_uart.sv
// Host UART model: sends 8N1 bytes, collects the block's bytes.
// Assumes baud code 3 and the bench clock.
`timescale 1ns/10ps
`default_nettype none
module hsp_host_uart (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic rts_n_o
);
  import hsp_pkg::*;
  localparam int BIT = int'(BIT_CYC[3]);
  logic [7:0] got_q[$];
  int frm_err = 0;
  // Idle line high; host accepts data, never holds off
  initial
  begin
    rxd_o = 1'b1;
    rts_n_o = 1'b0;
  end
  // low start, LSB first, high stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask
  always
  begin
    logic [7:0] b;
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk_i);
      b[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    if (txd_i !== 1'b1)
      frm_err++;
    got_q.push_back(b);
  end
endmodule // hsp_host_uart
`default_nettype wire

// File: verif/hsp_properties.sv
// Port checker of the host serial port control block.
// Bound to hsp_host_serial; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module hsp_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire hsp_pkg::hsp_wbm_t wb_i,
  input wire hsp_pkg::hsp_wbs_t wb_o,
  input wire logic txd_o,
  input wire logic cts_n_o,
  input wire hsp_pkg::hsp_rfout_t rf_out_o,
  input wire logic rf_out_ready_i,
  input wire hsp_pkg::hsp_mode_t mode_o
);
  import hsp_pkg::*;
  // Bus request not yet answered
  wire logic req = wb_i.cyc && wb_i.stb && !wb_o.ack;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; req |=> wb_o.ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_o.ack |=> !wb_o.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmap; req && !wb_i.we && wb_i.adr > REG_CTRL |=> wb_o.dat == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_wr_dat; req && wb_i.we |=> wb_o.dat == 32'h0; endproperty
  a_wr_dat: assert property (p_wr_dat) else $error("write answer data not zero");
  property p_out_hold; rf_out_o.valid && !rf_out_ready_i |=> rf_out_o.valid && $stable(rf_out_o.data); endproperty
  a_out_hold: assert property (p_out_hold) else $error("radio byte dropped while stalled");
  property p_onehot; $onehot(mode_o); endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");
  property p_tx_mode; $rose(rf_out_o.valid) |-> mode_o == M_TX; endproperty
  a_tx_mode: assert property (p_tx_mode) else $error("packet outside transmit mode");
  property p_start; $fell(txd_o) |=> !txd_o [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  // Status read shows the clear-to-send and mode levels of the request cycle
  property p_stat;
    wb_o.ack && $past(req) && !$past(wb_i.we) && $past(wb_i.adr) == REG_STATUS
      |-> wb_o.dat[4:0] == {$past(cts_n_o), $past(mode_o)};
  endproperty
  a_stat: assert property (p_stat) else $error("status flags differ from pins");
  // Main scenarios
  c_read: cover property (req && !wb_i.we);
  c_frame: cover property ($fell(txd_o));
  c_take: cover property (rf_out_o.valid && rf_out_ready_i);
endmodule // hsp_properties
`default_nettype wire

// File: verif/tb_top.sv
// Testbench top: bus, radio and host serial traffic.
// Assumes power-up defaults loaded during reset.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hsp_pkg::*;
  localparam int BIT = int'(BIT_CYC[3]);
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic nvm_i = 1'b1;
  hsp_wbm_t wbm = '0;
  hsp_wbs_t wbs;
  hsp_rfin_t rfi = '0;
  hsp_rfout_t rfo;
  hsp_mode_t mode;
  logic rdy = 1'b0;
  logic rxd, txd, rts_n, cts_n;
  logic [31:0] d;
  int error_cnt = 0;
  int compares = 0;
  int cyc_n = 0;
  initial forever #50 clk_i = ~clk_i;
  hsp_host_serial #(.MS_CYCLES(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .nvm_init_i(nvm_i), .wb_i(wbm),
    .wb_o(wbs), .rxd_i(rxd), .txd_o(txd), .rts_n_i(rts_n), .cts_n_o(cts_n), .rf_in_i(rfi), .rf_out_o(rfo),
    .rf_out_ready_i(rdy), .mode_o(mode));
  hsp_host_uart host (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd), .rts_n_o(rts_n));
  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_i);
    wbm <= '{1'b1, 1'b1, w, 4'hf, a, wd};
    // Request stands until ack is seen high at a rising edge
    do
      @(posedge clk_i);
    while (wbs.ack !== 1'b1);
    q = wbs.dat;
    wbm <= '0;
  endtask
  task automatic beat(input logic f, input logic l, input logic [7:0] n, input logic [7:0] b);
    @(posedge clk_i);
    rfi <= '{1'b1, f, l, n, b};
  endtask
  task automatic t_defaults;
    wb(1'b0, REG_CFG, 32'h0, d);
    chk("cfg", 32'h00002b13, d);
    wb(1'b0, REG_STATUS, 32'h0, d);
    chk("status", 32'h1, d & 32'h1f);
    chk("mode", 32'(M_IDLE), 32'(mode));
    chk("cts", 32'h0, 32'(cts_n));
    wb(1'b0, 8'h40, 32'h0, d);
    chk("unmapped", 32'h0, d);
    $display("t_defaults done");
  endtask
  task automatic t_radio;
    for (int i = 0; i < 129; i++)
      beat(i == 0, i == 128, 8'h81, 8'(i));
    beat(1'b1, 1'b0, 8'h02, 8'ha5);
    beat(1'b0, 1'b1, 8'h02, 8'h3c);
    @(posedge clk_i);
    rfi <= '0;
    while (host.got_q.size() < 2)
      @(posedge clk_i);
    chk("byte0", 32'ha5, 32'(host.got_q[0]));
    chk("byte1", 32'h3c, 32'(host.got_q[1]));
    chk("stop", 32'h0, 32'(host.frm_err));
    $display("t_radio done");
  endtask
  task automatic t_serial;
    wb(1'b1, REG_CTRL, 32'h1, d);
    // Lone escape character after long silence opens the entry window
    host.send_byte(CFG_DEFAULT.escape_char);
    wb(1'b0, REG_STATUS, 32'h0, d);
    chk("esc_one", 32'h1, (d >> 6) & 32'h3);
    repeat (BIT * 34) @(posedge clk_i);
    chk("held", 32'h0, 32'(rfo.valid));
    wb(1'b0, REG_STATUS, 32'h0, d);
    chk("esc_drop", 32'h0, (d >> 6) & 32'h3);
    wb(1'b1, REG_CTRL, 32'h0, d);
    while (rfo.valid !== 1'b1)
      @(negedge clk_i);
    chk("rf_data", {24'h000001, CFG_DEFAULT.escape_char}, {23'h0, rfo.last, rfo.data});
    repeat (4) @(posedge clk_i);
    rdy <= 1'b1;
    @(posedge clk_i);
    rdy <= 1'b0;
    @(negedge clk_i);
    chk("rf_done", 32'h0, 32'(rfo.valid));
    $display("t_serial done");
  endtask
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 90000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    nvm_i <= 1'b0;
    t_defaults();
    t_radio();
    t_serial();
    stop_test();
  end
endmodule // tb_top
bind hsp_host_serial hsp_properties u_prop (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .txd_o(txd_o),
  .cts_n_o(cts_n_o), .rf_out_o(rf_out_o), .rf_out_ready_i(rf_out_ready_i), .mode_o(mode_o));
`default_nettype wire
